// [oet_pkg.sv]
// Shared constants and types for the on-the-go elapsed timer.
// Assumes a single 20 MHz clock and an AXI4-Lite register port.
package oet_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Clock and step timing
  localparam int CLK_PERIOD_NS = 50;
  localparam int STEP_NS       = 10000;
  localparam int TICK_CYCLES   = STEP_NS / CLK_PERIOD_NS;

  ////////////////////////////////////////////////////////////////////////////
  // Timer field layout
  localparam int              COUNT_W   = 24;
  localparam logic [23:0]     COUNT_MAX = 24'hff_ffff;
  localparam int              RUN_BIT   = 31;
  localparam int              RUN_BYTE  = 3;
  localparam int              EVENT_W   = 8;

  ////////////////////////////////////////////////////////////////////////////
  // Register map, byte addresses
  localparam int              ADDR_W     = 4;
  localparam logic [3:0]      ADDR_TIMER = 4'h0;
  localparam logic [3:0]      ADDR_FLAGS = 4'h4;
  localparam logic [3:0]      ADDR_MASK  = 4'h8;

  ////////////////////////////////////////////////////////////////////////////
  // Bus responses and reset values
  localparam logic [1:0]      RESP_OKAY   = 2'h0;
  localparam logic [1:0]      RESP_SLVERR = 2'h2;
  localparam logic [7:0]      FLAGS_RST   = 8'h00;
  localparam logic [7:0]      MASK_RST    = 8'h00;

  typedef struct packed {
    logic               run;
    logic [COUNT_W-1:0] count;
  } oet_timer_t;

  localparam oet_timer_t TIMER_RST = '{run: 1'b0, count: 24'h00_0000};

  typedef enum logic [3:0] {
    DEC_TIMER = 4'b0001,
    DEC_FLAGS = 4'b0010,
    DEC_MASK  = 4'b0100,
    DEC_NONE  = 4'b1000
  } oet_reg_t;

endpackage

// [oet_tick_div.sv]
// Prescaler giving a one-cycle step enable every DIV clocks.
// Assumes restart_in and enable_in are synchronous to clk_in.
`timescale 1ns/1ps
module oet_tick_div #(
  parameter int DIV = oet_pkg::TICK_CYCLES
) (
  // Clock and reset
  input  wire logic clk_in,
  input  wire logic rst_in,
  // Control
  input  wire logic restart_in,
  input  wire logic enable_in,
  // Step enable
  output logic      tick_out
);
  import oet_pkg::*;

  localparam int CW = $clog2(DIV);
  localparam logic [CW-1:0] LAST = CW'(DIV - 1);

  logic [CW-1:0] cnt;
  logic [CW-1:0] next_cnt;
  logic          next_tick;

  initial
  begin
    if (DIV < 2)
      $error("DIV must be at least 2");
  end

  always_comb
  begin
    next_cnt  = cnt + CW'(1);
    next_tick = 1'b0;
    if (restart_in || !enable_in)
      next_cnt = '0;
    else if (cnt == LAST)
    begin
      next_cnt  = '0;
      next_tick = 1'b1;
    end
  end

  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      cnt      <= '0;
      tick_out <= 1'b0;
    end
    else
    begin
      cnt      <= next_cnt;
      tick_out <= next_tick;
    end
  end

  a_tick_wrap: assert property (@(posedge clk_in) disable iff (rst_in)
    tick_out |-> cnt == '0 && $past(cnt) == LAST)
    else $error("Step enable not at prescaler wrap");

endmodule

// [oet_timer.sv]
// Elapsed timer for the on-the-go logic with its AXI4-Lite register slave.
// Assumes event inputs are one-cycle pulses synchronous to clk_in.
`timescale 1ns/1ps

module oet_timer #(
  parameter int NUM_EVENTS = oet_pkg::EVENT_W,
  parameter int STEP_DIV   = oet_pkg::TICK_CYCLES
) (
  // Clock and reset
  input  wire logic                       clk_in,
  input  wire logic                       rst_in,
  // Event sources
  input  wire logic [NUM_EVENTS-1:0]      event_in,
  // Write address channel
  input  wire logic                       s_axi_awvalid_in,
  output logic                            s_axi_awready_out,
  input  wire logic [oet_pkg::ADDR_W-1:0] s_axi_awaddr_in,
  // Write data channel
  input  wire logic                       s_axi_wvalid_in,
  output logic                            s_axi_wready_out,
  input  wire logic [31:0]                s_axi_wdata_in,
  input  wire logic [3:0]                 s_axi_wstrb_in,
  // Write response channel
  output logic                            s_axi_bvalid_out,
  input  wire logic                       s_axi_bready_in,
  output logic [1:0]                      s_axi_bresp_out,
  // Read address channel
  input  wire logic                       s_axi_arvalid_in,
  output logic                            s_axi_arready_out,
  input  wire logic [oet_pkg::ADDR_W-1:0] s_axi_araddr_in,
  // Read data channel
  output logic                            s_axi_rvalid_out,
  input  wire logic                       s_axi_rready_in,
  output logic [31:0]                     s_axi_rdata_out,
  output logic [1:0]                      s_axi_rresp_out,
  // Timer state
  output oet_pkg::oet_timer_t             timer_out
);
  import oet_pkg::*;

  initial
  begin
    if (NUM_EVENTS < 1 || NUM_EVENTS > EVENT_W)
      $error("NUM_EVENTS must be 1 to 8");
    if (STEP_DIV < 2)
      $error("STEP_DIV must be at least 2");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Decoding

  function automatic oet_reg_t decode(input logic [ADDR_W-1:0] addr);
    unique case (addr)
      ADDR_TIMER: decode = DEC_TIMER;
      ADDR_FLAGS: decode = DEC_FLAGS;
      ADDR_MASK:  decode = DEC_MASK;
      default:    decode = DEC_NONE;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Write channels

  logic              aw_full;
  logic              w_full;
  logic [ADDR_W-1:0] aw_addr;
  logic [31:0]       w_data;
  logic [3:0]        w_strb;
  logic              next_aw_full;
  logic              next_w_full;
  logic [ADDR_W-1:0] next_aw_addr;
  logic [31:0]       next_w_data;
  logic [3:0]        next_w_strb;
  logic              next_awready;
  logic              next_wready;
  logic              next_bvalid;
  logic [1:0]        next_bresp;
  logic              do_write;
  oet_reg_t          wr_reg;

  // Address and data may come in either order; the write waits for both
  always_comb
  begin
    do_write     = aw_full && w_full && !s_axi_bvalid_out;
    wr_reg       = decode(aw_addr);
    next_aw_addr = aw_addr;
    next_w_data  = w_data;
    next_w_strb  = w_strb;
    next_aw_full = aw_full && !do_write;
    next_w_full  = w_full && !do_write;
    if (s_axi_awvalid_in && s_axi_awready_out)
    begin
      next_aw_full = 1'b1;
      next_aw_addr = s_axi_awaddr_in;
    end
    if (s_axi_wvalid_in && s_axi_wready_out)
    begin
      next_w_full = 1'b1;
      next_w_data = s_axi_wdata_in;
      next_w_strb = s_axi_wstrb_in;
    end
    next_bvalid = do_write || (s_axi_bvalid_out && !s_axi_bready_in);
    next_bresp  = s_axi_bresp_out;
    if (do_write)
      next_bresp = (wr_reg == DEC_NONE) ? RESP_SLVERR : RESP_OKAY;
    next_awready = !next_aw_full && !next_bvalid;
    next_wready  = !next_w_full && !next_bvalid;
  end

  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      aw_full           <= 1'b0;
      w_full            <= 1'b0;
      aw_addr           <= '0;
      w_data            <= 32'h0000_0000;
      w_strb            <= 4'h0;
      s_axi_awready_out <= 1'b0;
      s_axi_wready_out  <= 1'b0;
      s_axi_bvalid_out  <= 1'b0;
      s_axi_bresp_out   <= RESP_OKAY;
    end
    else
    begin
      aw_full           <= next_aw_full;
      w_full            <= next_w_full;
      aw_addr           <= next_aw_addr;
      w_data            <= next_w_data;
      w_strb            <= next_w_strb;
      s_axi_awready_out <= next_awready;
      s_axi_wready_out  <= next_wready;
      s_axi_bvalid_out  <= next_bvalid;
      s_axi_bresp_out   <= next_bresp;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Event flags and mask

  logic [NUM_EVENTS-1:0] flags;
  logic [NUM_EVENTS-1:0] mask;
  logic [NUM_EVENTS-1:0] next_flags;
  logic [NUM_EVENTS-1:0] next_mask;
  logic                  pending;

  // A new event beats a clear in the same cycle
  always_comb
  begin
    next_flags = flags;
    next_mask  = mask;
    if (do_write && w_strb[0] && wr_reg == DEC_FLAGS)
      next_flags = flags & ~w_data[NUM_EVENTS-1:0];
    if (do_write && w_strb[0] && wr_reg == DEC_MASK)
      next_mask = w_data[NUM_EVENTS-1:0];
    next_flags = next_flags | event_in;
    pending    = |(flags & mask);
  end

  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      flags <= FLAGS_RST[NUM_EVENTS-1:0];
      mask  <= MASK_RST[NUM_EVENTS-1:0];
    end
    else
    begin
      flags <= next_flags;
      mask  <= next_mask;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Timer core

  logic       tick;
  logic       run_wr;
  logic       start_cmd;
  logic       stop_cmd;
  oet_timer_t next_timer;

  oet_tick_div #(
    .DIV        (STEP_DIV)
  ) u_div (
    .clk_in     (clk_in),
    .rst_in     (rst_in),
    .restart_in (start_cmd),
    .enable_in  (timer_out.run),
    .tick_out   (tick)
  );

  // A start while an enabled event pends zeroes the count but cannot run
  always_comb
  begin
    run_wr     = do_write && wr_reg == DEC_TIMER && w_strb[RUN_BYTE];
    start_cmd  = run_wr && w_data[RUN_BIT];
    stop_cmd   = run_wr && !w_data[RUN_BIT];
    next_timer = timer_out;
    // A stop landing on a step keeps the count it had, not one more
    if (timer_out.run && tick && !pending && !stop_cmd)
    begin
      next_timer.count = timer_out.count + COUNT_W'(1);
      if (next_timer.count == COUNT_MAX)
        next_timer.run = 1'b0;
    end
    if (pending)
      next_timer.run = 1'b0;
    if (stop_cmd)
      next_timer.run = 1'b0;
    if (start_cmd)
    begin
      next_timer.count = '0;
      next_timer.run   = !pending;
    end
  end

  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
      timer_out <= TIMER_RST;
    else
      timer_out <= next_timer;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read channel

  logic        next_rvalid;
  logic        next_arready;
  logic [31:0] next_rdata;
  logic [1:0]  next_rresp;
  logic        ar_take;

  // Data is captured at the address handshake and held until taken
  always_comb
  begin
    ar_take     = s_axi_arvalid_in && s_axi_arready_out;
    next_rdata  = s_axi_rdata_out;
    next_rresp  = s_axi_rresp_out;
    next_rvalid = ar_take || (s_axi_rvalid_out && !s_axi_rready_in);
    if (ar_take)
    begin
      next_rdata = 32'h0000_0000;
      next_rresp = RESP_OKAY;
      unique case (decode(s_axi_araddr_in))
        DEC_TIMER:
        begin
          next_rdata[RUN_BIT]     = timer_out.run;
          next_rdata[COUNT_W-1:0] = timer_out.count;
        end
        DEC_FLAGS: next_rdata[NUM_EVENTS-1:0] = flags;
        DEC_MASK:  next_rdata[NUM_EVENTS-1:0] = mask;
        DEC_NONE:  next_rresp = RESP_SLVERR;
      endcase
    end
    next_arready = !next_rvalid;
  end

  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      s_axi_rvalid_out  <= 1'b0;
      s_axi_arready_out <= 1'b0;
      s_axi_rdata_out   <= 32'h0000_0000;
      s_axi_rresp_out   <= RESP_OKAY;
    end
    else
    begin
      s_axi_rvalid_out  <= next_rvalid;
      s_axi_arready_out <= next_arready;
      s_axi_rdata_out   <= next_rdata;
      s_axi_rresp_out   <= next_rresp;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  // Cycles since the last step or start, saturating
  logic [15:0] gap;

  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
      gap <= 16'h0000;
    else if (start_cmd)
      gap <= 16'h0000;
    else if (tick)
      gap <= 16'h0001;
    else if (gap != 16'hffff)
      gap <= gap + 16'h0001;
  end

  sequence s_start;
    start_cmd && !pending;
  endsequence

  sequence s_running_from_zero;
    timer_out.run && timer_out.count == '0;
  endsequence

  a_start_zeroes: assert property (@(posedge clk_in) disable iff (rst_in)
    s_start |=> s_running_from_zero)
    else $error("Start did not zero and run the count");

  a_max_stops: assert property (@(posedge clk_in) disable iff (rst_in)
    timer_out.count == COUNT_MAX |-> !timer_out.run)
    else $error("Timer still running at full count");

  a_stop_holds: assert property (@(posedge clk_in) disable iff (rst_in)
    stop_cmd |=> !timer_out.run && timer_out.count == $past(timer_out.count))
    else $error("Stop did not halt and keep the count");

  a_event_freeze: assert property (@(posedge clk_in) disable iff (rst_in)
    timer_out.run && pending && !start_cmd
    |=> !timer_out.run && timer_out.count == $past(timer_out.count))
    else $error("Enabled event did not freeze the timer");

  a_read_count: assert property (@(posedge clk_in) disable iff (rst_in)
    ar_take && s_axi_araddr_in == ADDR_TIMER
    |=> s_axi_rvalid_out && s_axi_rdata_out[COUNT_W-1:0] == $past(timer_out.count)
        && s_axi_rdata_out[30:24] == 7'h00)
    else $error("Timer read returned wrong count");

  a_step_once: assert property (@(posedge clk_in) disable iff (rst_in)
    timer_out.run && !tick && !run_wr |=> $stable(timer_out.count))
    else $error("Count moved without a step");

  a_step_adds: assert property (@(posedge clk_in) disable iff (rst_in)
    timer_out.run && tick && !pending && !run_wr
    |=> timer_out.count == $past(timer_out.count) + COUNT_W'(1))
    else $error("Step did not add one");

  a_step_period: assert property (@(posedge clk_in) disable iff (rst_in)
    tick |-> gap == 16'(STEP_DIV))
    else $error("Step spacing differs from the prescaler period");

  a_write_resp: assert property (@(posedge clk_in) disable iff (rst_in)
    do_write |=> s_axi_bvalid_out && !s_axi_awready_out)
    else $error("Write did not answer one cycle later");

endmodule

// [tb.sv]
// Self-checking bench for the on-the-go elapsed timer, with a cycle-count model.
// Assumes oet_pkg is compiled first; drives the AXI4-Lite port itself.
`timescale 1ns/1ps
module tb;
  import oet_pkg::*;
  // Short step keeps the run brief; the step waits scale from it, the 3-cycle event waits do not
  localparam int DIV   = 4;
  localparam int LIMIT = 20000;

  logic              clk_in;
  logic              rst_in;
  logic [7:0]        event_in;
  logic              awvalid, awready, wvalid, wready, bvalid, bready;
  logic              arvalid, arready, rvalid, rready;
  logic [3:0]        awaddr, araddr, wstrb;
  logic [31:0]       wdata, rdata, d;
  logic [1:0]        bresp, rresp, r;
  oet_timer_t        tmr;
  logic [15:0]       rnd;
  logic [23:0]       snap;
  int                failures, comparisons, cycle_cnt, t0, i, j, est;

  oet_timer #(.NUM_EVENTS(8), .STEP_DIV(DIV)) dut (
    .clk_in(clk_in), .rst_in(rst_in), .event_in(event_in),
    .s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready), .s_axi_awaddr_in(awaddr),
    .s_axi_wvalid_in(wvalid), .s_axi_wready_out(wready), .s_axi_wdata_in(wdata),
    .s_axi_wstrb_in(wstrb), .s_axi_bvalid_out(bvalid), .s_axi_bready_in(bready),
    .s_axi_bresp_out(bresp), .s_axi_arvalid_in(arvalid), .s_axi_arready_out(arready),
    .s_axi_araddr_in(araddr), .s_axi_rvalid_out(rvalid), .s_axi_rready_in(rready),
    .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp), .timer_out(tmr));

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    clk_in = 1'b0;
    forever #25 clk_in = ~clk_in;
  end

  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      failures++;
      $display("mismatch at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic final_report;
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // Hang guard: the whole sequence needs far fewer cycles
  always @(posedge clk_in)
  begin
    cycle_cnt++;
    if (cycle_cnt == LIMIT)
    begin
      failures++;
      final_report;
    end
  end

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Bus cycles: request held until its own ready, answer taken at its edge
  task automatic axi_write(input logic [3:0] a, input logic [31:0] dat, input logic [3:0] s,
                           output logic [1:0] rsp);
    @(posedge clk_in);
    awvalid <= 1'b1;
    awaddr  <= a;
    wvalid  <= 1'b1;
    wdata   <= dat;
    wstrb   <= s;
    bready  <= 1'b1;
    forever
    begin
      @(posedge clk_in);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid)
      begin
        rsp = bresp;
        bready <= 1'b0;
        break;
      end
    end
  endtask

  task automatic axi_read(input logic [3:0] a, output logic [31:0] dat, output logic [1:0] rsp);
    @(posedge clk_in);
    arvalid <= 1'b1;
    araddr  <= a;
    rready  <= 1'b1;
    forever
    begin
      @(posedge clk_in);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid)
      begin
        dat = rdata;
        rsp = rresp;
        rready <= 1'b0;
        break;
      end
    end
  endtask

  task automatic pulse(input int b);
    @(posedge clk_in);
    event_in <= 8'h01 << b;
    @(posedge clk_in);
    event_in <= 8'h00;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    rst_in = 1'b1;
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, araddr, wstrb, wdata, event_in} = '0;
    {failures, comparisons, cycle_cnt} = '0;
    rnd = 16'h4fe4;
    repeat (3) @(posedge clk_in);
    rst_in <= 1'b0;

    // Reset values, unmapped place, strobe gating of the run bit
    axi_read(ADDR_TIMER, d, r);
    check(d, 32'h0000_0000);
    axi_read(ADDR_MASK, d, r);
    check(d, 32'h0000_0000);
    axi_read(4'hc, d, r);
    check(d, 32'h0000_0000);
    check(r, RESP_SLVERR);
    axi_write(4'hc, 32'hffff_ffff, 4'hf, r);
    check(r, RESP_SLVERR);
    axi_write(ADDR_TIMER, 32'h8000_0000, 4'h1, r);
    check(r, RESP_OKAY);
    cyc(2);
    check(tmr.run, 1'b0);
    $display("test reset_map done");

    // Start with random ignored bits, step rate, live read, stop and hold
    rnd = lfsr_next(rnd);
    axi_write(ADDR_TIMER, {1'b1, rnd[6:0], 8'h00, rnd}, 4'hf, r);
    t0 = cycle_cnt;
    check({tmr.run, tmr.count}, {1'b1, 24'h0});
    cyc(DIV - 2);
    check(tmr.count, 24'h0);
    snap = tmr.count;
    while (tmr.count === snap) cyc(1);
    snap = tmr.count;
    cyc(5 * DIV);
    check(tmr.count, snap + 24'd5);
    cyc(rnd[7:0]);
    axi_read(ADDR_TIMER, d, r);
    check(d[31:24], 8'h80);
    axi_write(ADDR_TIMER, 32'h0, 4'hf, r);
    est = (cycle_cnt - t0) / DIV;
    snap = tmr.count;
    check(32'(snap) + 2 >= est && 32'(snap) <= est + 2, 1'b1);
    cyc(3 * DIV);
    check({tmr.run, tmr.count}, {1'b0, snap});
    axi_read(ADDR_TIMER, d, r);
    check(d, {8'h00, snap});
    axi_write(ADDR_TIMER, 32'h8000_0000, 4'hf, r);
    check({tmr.run, tmr.count}, {1'b1, 24'h0});
    axi_write(ADDR_TIMER, 32'h0, 4'hf, r);
    $display("test start_stop done");

    // Each event line: unmasked one ignored, masked one freezes the count
    for (i = 0; i < 8; i++)
    begin
      rnd = lfsr_next(rnd);
      j = (i + 1 + rnd % 7) % 8;
      axi_write(ADDR_MASK, 32'h1 << i, 4'h1, r);
      axi_read(ADDR_MASK, d, r);
      check(d, 32'h1 << i);
      axi_write(ADDR_TIMER, 32'h8000_0000, 4'hf, r);
      cyc(3 * DIV);
      pulse(j);
      cyc(3);
      check(tmr.run, 1'b1);
      pulse(i);
      cyc(3);
      check(tmr.run, 1'b0);
      snap = tmr.count;
      cyc(2 * DIV);
      check(tmr.count, snap);
      axi_read(ADDR_FLAGS, d, r);
      check(d, (32'h1 << i) | (32'h1 << j));
      axi_write(ADDR_TIMER, 32'h8000_0000, 4'hf, r);
      cyc(DIV * 2);
      check({tmr.run, tmr.count}, {1'b0, 24'h0});
      axi_write(ADDR_FLAGS, 32'hff, 4'h1, r);
      axi_read(ADDR_FLAGS, d, r);
      check(d, 32'h0);
    end
    $display("test events done");
    final_report;
  end
endmodule
